// >>> hw/cell_counter_access_status.sv
`timescale 1ns/10ps
// Overview of operation
// - per-link bit picks all or user cells
// - output clock missing sets latched status bit 3
// - input clock missing sets latched status bit 2
// - status bit 1 flags transmit fifo overflow
// - no free cell buffer sets status bit 0
// - latch mode off, strobe, every 8000, software
// - software latch on bit 10 rising write
// - bit 7 reads done, software writes 0
// - bit 6 toggles on every host write
// - enable value moves only for command 10
// - bit 2 chooses write-in or read-out direction
// - command 00 clear, 01 value, 10 enable
// - command register resets to 0x0080
// - reserved bits 11, 5, 4 written zero
// - status bits 15:4 read zero
// - byte-3 holding register carries counter msb
// - select holds counter type and link
// - overflow bits latch until written zero
module cell_counter_access_status #(
   parameter int N_LINKS   = cca_pkg::N_LINKS_DEF,
   parameter int LATCH_DIV = cca_pkg::LATCH_DIV_DEF
) (
   input  wire logic                     clk,
   input  wire logic                     arst_n,
   input  wire cca_pkg::host_req_t       host_req,
   output logic [15:0]                   host_rdata,
   input  wire logic                     counter_latch_strobe,
   input  wire cca_pkg::status_evt_t     status_evt,
   input  wire logic [N_LINKS-1:0][15:0] ovf_set,
   output logic [15:0]                   input_count_mode,
   output logic                          counter_latch,
   output cca_pkg::cnt_req_t             cnt_req,
   input  wire cca_pkg::cnt_rsp_t        cnt_rsp
);
   import cca_pkg::*;

   if (N_LINKS < 1 || N_LINKS > 16)
   begin : g_bad_links
      $error("N_LINKS must lie between 1 and 16");
   end

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   // true when the word address falls in the per-link overflow window
   function automatic logic is_ovf(input logic [ADDR_W-1:0] a);
      return (a[ADDR_W-1:4] == A_OVF_BASE[ADDR_W-1:4]) && ({1'b0, a[3:0]} < 5'(N_LINKS));
   endfunction

   // command field and direction into a counter-side operation
   function automatic cnt_op_t cmd_to_op(input logic [1:0] f, input logic dir);
      cnt_op_t op;
      op = OP_CLEAR;
      case (cmd_field_t'(f))
         CF_CLEAR: op = OP_CLEAR;
         CF_VALUE: op = dir ? OP_RD_VAL : OP_WR_VAL;
         CF_IE:    op = dir ? OP_RD_IE : OP_WR_IE;
         default:  op = OP_CLEAR;
      endcase
      return op;
   endfunction

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   logic [15:0]               count_mode_r;  // one bit per link
   logic [3:0]                gs_r;          // latched general status
   latch_mode_t               lmode_r;       // bits 9:8
   logic                      swl_r;         // bit 10 as last written
   logic                      ie_r;          // bit 3
   logic                      dir_r;         // bit 2
   logic [1:0]                cfield_r;      // bits 1:0
   logic                      toggle_r;      // bit 6
   logic [8:0]                sel_r;         // counter select
   logic [7:0]                byte3_r;       // holding byte 3
   logic [15:0]               b21_r;         // holding bytes 2 and 1
   cnt_op_t                   op_r;          // operation in flight
   logic [N_LINKS-1:0][15:0]  ovf_r;         // per-link overflow flags
   logic [N_LINKS-1:0][15:0]  ovf_nxt;
   logic                      sw_latch_r;    // software latch pulse
   logic [15:0]               rdata_r;
   logic [3:0]                gs_nxt;

   // ------------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------------
   wire       wr      = host_req.wr;
   wire [15:0] wd     = host_req.wdata;
   wire       wr_mode = wr && (host_req.addr == A_COUNT_MODE);
   wire       wr_gs   = wr && (host_req.addr == A_GEN_STATUS);
   wire       wr_cmd  = wr && (host_req.addr == A_XFER_CMD);
   wire       wr_b3   = wr && (host_req.addr == A_BYTE3);
   wire       wr_b21  = wr && (host_req.addr == A_BYTES21);
   wire       wr_sel  = wr && (host_req.addr == A_CNT_SEL);
   wire       ovf_hit = is_ovf(host_req.addr);
   wire [3:0] ovf_idx = host_req.addr[3:0];

   // ------------------------------------------------------------------
   // command decode and transfer engine
   // ------------------------------------------------------------------
   wire       xfer_done;
   wire       req_valid;
   wire [1:0] wr_field = wd[1:0];
   // field 11 starts nothing, so latch-mode writes need not disturb counters
   wire       start    = wr_cmd && (cmd_field_t'(wr_field) != CF_NONE);
   wire       take     = start && xfer_done;
   wire       rd_back  = cnt_rsp.ack && req_valid;
   wire       sw_rise  = wr_cmd && wd[CMD_SWLATCH_BIT] && !swl_r
                         && (latch_mode_t'(wd[CMD_LMODE_LO+:2]) == LM_SW);

   counter_transfer_engine u_engine (
      .clk       (clk),
      .arst_n    (arst_n),
      .start     (start),
      .ack       (cnt_rsp.ack),
      .done      (xfer_done),
      .req_valid (req_valid)
   );

   // ------------------------------------------------------------------
   // hardware latching from the strobe pin
   // ------------------------------------------------------------------
   wire strobe_latch;

   latch_strobe_divider #(
      .LATCH_DIV (LATCH_DIV)
   ) u_divider (
      .clk         (clk),
      .arst_n      (arst_n),
      .strobe      (counter_latch_strobe),
      .mode        (lmode_r),
      .latch_pulse (strobe_latch)
   );

   assign counter_latch = strobe_latch | sw_latch_r;

   // ------------------------------------------------------------------
   // latched status: a set in the clearing cycle wins
   // ------------------------------------------------------------------
   wire [3:0] gs_set  = {status_evt.out_clk_slow, status_evt.in_clk_slow,
                         status_evt.tx_fifo_ovf, status_evt.cell_ram_full};
   wire [3:0] gs_keep = wr_gs ? wd[3:0] : GS_ALL;

   always_comb
   begin
      gs_nxt = (gs_r & gs_keep) | gs_set;
      for (int i = 0; i < N_LINKS; i++)
      begin
         // writing 0 clears, writing 1 leaves the flag alone
         ovf_nxt[i] = ovf_r[i];
         if (wr && ovf_hit && (ovf_idx == 4'(i)))
            ovf_nxt[i] = ovf_r[i] & wd;
         ovf_nxt[i] = (ovf_nxt[i] | ovf_set[i]) & OVF_MASK;
      end
   end

   // ------------------------------------------------------------------
   // status registers
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         gs_r  <= ZERO_RESET[3:0];
         ovf_r <= '0;
      end
      else
      begin
         gs_r  <= gs_nxt;
         ovf_r <= ovf_nxt;
      end
   end

   // ------------------------------------------------------------------
   // control registers written by the host
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         count_mode_r <= ZERO_RESET;
         lmode_r      <= latch_mode_t'(CMD_RESET[CMD_LMODE_LO+:2]);
         swl_r        <= CMD_RESET[CMD_SWLATCH_BIT];
         ie_r         <= CMD_RESET[CMD_IE_BIT];
         dir_r        <= CMD_RESET[CMD_DIR_BIT];
         cfield_r     <= CMD_RESET[1:0];
         toggle_r     <= CMD_RESET[CMD_TOGGLE_BIT];
         sw_latch_r   <= 1'b0;
         sel_r        <= ZERO_RESET[8:0];
      end
      else
      begin
         sw_latch_r <= sw_rise;
         if (wr)
            toggle_r <= ~toggle_r;
         if (wr_mode)
            count_mode_r <= wd;
         if (wr_sel)
            sel_r <= wd[8:0];
         if (wr_cmd)
         begin
            // bits 11, 5, 4 and 7 are not stored; bit 6 follows writes only
            lmode_r  <= latch_mode_t'(wd[CMD_LMODE_LO+:2]);
            swl_r    <= wd[CMD_SWLATCH_BIT];
            dir_r    <= wd[CMD_DIR_BIT];
            cfield_r <= wr_field;
         end
         // a read-back of the enable bit overrides the host copy
         if (rd_back && (op_r == OP_RD_IE))
            ie_r <= cnt_rsp.ie;
         else if (wr_cmd)
            ie_r <= wd[CMD_IE_BIT];
      end
   end

   // ------------------------------------------------------------------
   // holding registers and the operation in flight
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         byte3_r <= ZERO_RESET[7:0];
         b21_r   <= ZERO_RESET;
         op_r    <= OP_CLEAR;
      end
      else
      begin
         if (take)
            op_r <= cmd_to_op(wr_field, wd[CMD_DIR_BIT]);
         // completion wins over a host write, which the host must not make
         if (rd_back && (op_r == OP_RD_VAL))
         begin
            byte3_r <= cnt_rsp.rdata[23:16];
            b21_r   <= cnt_rsp.rdata[15:0];
         end
         else
         begin
            if (wr_b3)
               byte3_r <= wd[7:0];
            if (wr_b21)
               b21_r <= wd;
         end
      end
   end

   // ------------------------------------------------------------------
   // request toward the counters
   // ------------------------------------------------------------------
   assign cnt_req.valid = req_valid;
   assign cnt_req.op    = op_r;
   assign cnt_req.ctype = sel_r[SEL_TYPE_LO+:4];
   assign cnt_req.link  = sel_r[SEL_TYPE_LO-1:0];
   assign cnt_req.wdata = {byte3_r, b21_r};
   assign cnt_req.ie    = ie_r;
   assign input_count_mode = count_mode_r;

   // ------------------------------------------------------------------
   // read path; unmapped words read zero, data held until next read
   // ------------------------------------------------------------------
   wire [15:0] cmd_view = {5'h00, swl_r, lmode_r, xfer_done, toggle_r,
                           2'b00, ie_r, dir_r, cfield_r};
   wire [15:0] rd_mux =
      (host_req.addr == A_COUNT_MODE) ? count_mode_r :
      (host_req.addr == A_GEN_STATUS) ? {12'h000, gs_r} :
      (host_req.addr == A_XFER_CMD)   ? cmd_view :
      (host_req.addr == A_BYTE3)      ? {8'h00, byte3_r} :
      (host_req.addr == A_BYTES21)    ? b21_r :
      (host_req.addr == A_CNT_SEL)    ? {7'h00, sel_r} :
      ovf_hit                         ? ovf_r[ovf_idx] : 16'h0000;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         rdata_r <= ZERO_RESET;
      else if (host_req.rd)
         rdata_r <= rd_mux;
   end

   assign host_rdata = rdata_r;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   mode_write_a : assert property (@(posedge clk) disable iff (!arst_n)
      wr_mode |=> input_count_mode == $past(wd))
      else $error("count mode not taken from write");
   out_clk_a : assert property (@(posedge clk) disable iff (!arst_n)
      status_evt.out_clk_slow |=> gs_r[3] ##1 (gs_r[3] || $past(wr_gs)))
      else $error("output clock flag not latched");
   in_clk_hold_a : assert property (@(posedge clk) disable iff (!arst_n)
      gs_r[2] && !(wr_gs && !wd[2]) |=> gs_r[2])
      else $error("input clock flag lost without clear");
   fifo_ovf_a : assert property (@(posedge clk) disable iff (!arst_n)
      status_evt.tx_fifo_ovf && wr_gs |=> gs_r[1])
      else $error("fifo overflow lost to clear");
   ram_clear_a : assert property (@(posedge clk) disable iff (!arst_n)
      wr_gs && !wd[0] && !status_evt.cell_ram_full |=> !gs_r[0])
      else $error("cell ram flag not cleared");
   sw_latch_a : assert property (@(posedge clk) disable iff (!arst_n)
      wr_cmd && !wd[CMD_SWLATCH_BIT] |=> !sw_latch_r)
      else $error("zero write caused a latch");
   toggle_flip_a : assert property (@(posedge clk) disable iff (!arst_n)
      wr |=> toggle_r != $past(toggle_r))
      else $error("toggle bit did not flip");
   status_zero_a : assert property (@(posedge clk) disable iff (!arst_n)
      host_req.rd && (host_req.addr == A_GEN_STATUS) |=> host_rdata[15:4] == 12'h000)
      else $error("unused status bits read nonzero");
   done_read_a : assert property (@(posedge clk) disable iff (!arst_n)
      host_req.rd && (host_req.addr == A_XFER_CMD)
      |=> host_rdata[CMD_DONE_BIT] == $past(xfer_done))
      else $error("done bit read wrong");

endmodule

// >>> hw/counter_transfer_engine.sv
`timescale 1ns/10ps
module counter_transfer_engine (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic start,      // command written this cycle
   input  wire logic ack,        // counter side finished
   output logic      done,       // transfer-done flag
   output logic      req_valid   // request held toward the counters
);
   import cca_pkg::*;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_BUSY = 1'b1
   } xfer_state_t;

   xfer_state_t state_r;
   xfer_state_t state_nxt;

   // ------------------------------------------------------------------
   // next state; a start while busy is dropped, the host must poll first
   // ------------------------------------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: if (start) state_nxt = ST_BUSY;
         ST_BUSY: if (ack) state_nxt = ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         state_r <= ST_IDLE;
      else
         state_r <= state_nxt;
   end

   assign done      = (state_r == ST_IDLE);
   assign req_valid = (state_r == ST_BUSY);

   done_drop_a : assert property (@(posedge clk) disable iff (!arst_n)
      done && start |=> !done ##0 req_valid)
      else $error("done did not drop on command");
   done_rise_a : assert property (@(posedge clk) disable iff (!arst_n)
      req_valid && ack |=> done)
      else $error("done did not return after ack");

endmodule

// >>> hw/latch_strobe_divider.sv
`timescale 1ns/10ps
module latch_strobe_divider #(
   parameter int LATCH_DIV = cca_pkg::LATCH_DIV_DEF
) (
   input  wire logic                clk,
   input  wire logic                arst_n,
   input  wire logic                strobe,      // counter_latch_strobe, synchronous
   input  wire cca_pkg::latch_mode_t mode,
   output logic                     latch_pulse  // one cycle per latch
);
   import cca_pkg::*;

   localparam int CW = $clog2(LATCH_DIV);

   if (LATCH_DIV < 2)
   begin : g_bad_div
      $error("LATCH_DIV must be at least 2");
   end

   logic          strobe_r;   // previous strobe level
   logic [CW-1:0] edges_r;    // rising edges seen in divide mode
   logic          pulse_r;
   wire           rise     = strobe & ~strobe_r;
   wire           last_one = (edges_r == CW'(LATCH_DIV - 1));

   // ------------------------------------------------------------------
   // edge counting; counter parks at zero outside divide mode
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         strobe_r <= 1'b0;
         edges_r  <= '0;
         pulse_r  <= 1'b0;
      end
      else
      begin
         strobe_r <= strobe;
         pulse_r  <= rise & ((mode == LM_EDGE) | ((mode == LM_DIV) & last_one));
         if (mode != LM_DIV)
            edges_r <= '0;
         else if (rise)
            edges_r <= last_one ? '0 : edges_r + 1'b1;
      end
   end

   assign latch_pulse = pulse_r;

   edge_latch_a : assert property (@(posedge clk) disable iff (!arst_n)
      (mode == LM_EDGE) && rise |=> latch_pulse)
      else $error("edge mode missed a latch");
   off_quiet_a : assert property (@(posedge clk) disable iff (!arst_n)
      $past(mode) == LM_OFF |-> !latch_pulse)
      else $error("latch while latching disabled");

endmodule

// >>> include/cca_pkg.sv
package cca_pkg;

   // ------------------------------------------------------------------
   // bus geometry and register word addresses
   // ------------------------------------------------------------------
   localparam int                ADDR_W        = 11;
   localparam int                N_LINKS_DEF   = 16;
   localparam int                LATCH_DIV_DEF = 8000;   // strobe edges per latch in divide mode
   localparam logic [ADDR_W-1:0] A_COUNT_MODE  = 11'h402;
   localparam logic [ADDR_W-1:0] A_GEN_STATUS  = 11'h40E;
   localparam logic [ADDR_W-1:0] A_XFER_CMD    = 11'h40F;
   localparam logic [ADDR_W-1:0] A_OVF_BASE    = 11'h410; // one word per link, up to 0x41F
   localparam logic [ADDR_W-1:0] A_BYTE3       = 11'h430;
   localparam logic [ADDR_W-1:0] A_BYTES21     = 11'h431;
   localparam logic [ADDR_W-1:0] A_CNT_SEL     = 11'h432;

   // ------------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------------
   localparam int          CMD_SWLATCH_BIT = 10;
   localparam int          CMD_LMODE_LO    = 8;
   localparam int          CMD_DONE_BIT    = 7;
   localparam int          CMD_TOGGLE_BIT  = 6;
   localparam int          CMD_IE_BIT      = 3;
   localparam int          CMD_DIR_BIT     = 2;
   localparam int          SEL_TYPE_LO     = 5;
   localparam logic [15:0] CMD_RESET       = 16'h0080;
   localparam logic [15:0] ZERO_RESET      = 16'h0000;
   localparam logic [3:0]  GS_ALL          = 4'hF;
   localparam logic [15:0] OVF_MASK        = 16'h1FCE; // bits 12:6 and 3:1 are live

   // ------------------------------------------------------------------
   // enumerations
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      LM_OFF  = 2'b00,
      LM_EDGE = 2'b01,
      LM_DIV  = 2'b10,
      LM_SW   = 2'b11
   } latch_mode_t;

   typedef enum logic [1:0] {
      CF_CLEAR = 2'b00,
      CF_VALUE = 2'b01,
      CF_IE    = 2'b10,
      CF_NONE  = 2'b11
   } cmd_field_t;

   typedef enum logic [2:0] {
      OP_CLEAR  = 3'b000,
      OP_WR_VAL = 3'b001,
      OP_RD_VAL = 3'b010,
      OP_WR_IE  = 3'b011,
      OP_RD_IE  = 3'b100
   } cnt_op_t;

   // ------------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic              wr;     // one-cycle write strobe
      logic              rd;     // one-cycle read strobe
      logic [ADDR_W-1:0] addr;   // word address
      logic [15:0]       wdata;
   } host_req_t;

   typedef struct packed {
      logic        valid;        // held until ack
      cnt_op_t     op;
      logic [3:0]  ctype;
      logic [4:0]  link;
      logic [23:0] wdata;
      logic        ie;
   } cnt_req_t;

   typedef struct packed {
      logic        ack;          // one-cycle completion pulse
      logic [23:0] rdata;
      logic        ie;
   } cnt_rsp_t;

   typedef struct packed {
      logic out_clk_slow;        // cell-bus output clock missing
      logic in_clk_slow;         // cell-bus input clock missing
      logic tx_fifo_ovf;         // a transmit cell-bus fifo overflowed
      logic cell_ram_full;       // no free transmit cell buffer
   } status_evt_t;

endpackage

// >>> verif/cell_counter_access_status_test.sv
`timescale 1ns/10ps
module cell_counter_access_status_test;
   import cca_pkg::*;
   logic              clk, arst_n, strobe, latch;
   host_req_t         hq;
   logic [15:0]       rdata, mode_q, v;
   status_evt_t       evt;
   logic [15:0][15:0] ovf;
   cnt_req_t          creq;
   cnt_rsp_t          crsp;
   logic [3:0]        lag;
   int                n_fail, compares, n_latch, tog;
   cell_counter_access_status #(.N_LINKS(16), .LATCH_DIV(4)) u_cell_counter_access_status (
      .clk(clk), .arst_n(arst_n), .host_req(hq), .host_rdata(rdata),
      .counter_latch_strobe(strobe), .status_evt(evt), .ovf_set(ovf),
      .input_count_mode(mode_q), .counter_latch(latch), .cnt_req(creq), .cnt_rsp(crsp));
   counter_store_model u_counter_store_model (
      .clk(clk), .arst_n(arst_n), .lag(lag), .req(creq), .rsp(crsp));
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) if (latch === 1'b1) n_latch++;
   task automatic chk(input logic [15:0] got, exp, msk);
      compares++;
      if ((got & msk) !== (exp & msk))
      begin
         n_fail++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // host write: bit 6 of the command view flips on every one
   task automatic wr(input logic [10:0] a, input logic [15:0] d);
      @(negedge clk);
      hq = '{1'b1, 1'b0, a, d};
      tog ^= 1;
      @(negedge clk);
      hq.wr = 1'b0;
   endtask
   task automatic rd(input logic [10:0] a);
      @(negedge clk);
      hq = '{1'b0, 1'b1, a, 16'h0000};
      @(negedge clk);
      hq.rd = 1'b0;
      v = rdata;
   endtask
   task automatic rchk(input logic [10:0] a, input logic [15:0] e);
      rd(a);
      if (a == A_XFER_CMD) chk(v, e | 16'(tog << 6), 16'hFFDF);
      else chk(v, e, 16'hFFFF);
   endtask
   // bounded poll: the host may not stack commands
   task automatic poll();
      int i;
      i = 0;
      do begin rd(A_XFER_CMD); i++; end while (v[7] !== 1'b1 && i < 40);
      chk(16'(v[7]), 16'h0001, 16'hFFFF);
   endtask
   task automatic cmd(input logic [15:0] d);
      wr(A_XFER_CMD, d);
      poll();
   endtask
   task automatic strobes(input int n, input logic [15:0] e);
      // the count runs from the last check, so software latches made
      // before a call are counted too
      repeat (n)
      begin
         @(negedge clk) strobe = 1'b1;
         @(negedge clk) strobe = 1'b0;
      end
      repeat (4) @(negedge clk);
      chk(16'(n_latch), e, 16'hFFFF);
      n_latch = 0;
   endtask
   task automatic end_of_test();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      #100000;
      n_fail++;
      end_of_test();
   end
   initial
   begin
      {strobe, hq, evt, ovf, lag, tog, n_fail, compares, n_latch} = '0;
      arst_n = 1'b0;
      repeat (16) @(negedge clk);
      arst_n = 1'b1;
      rchk(A_XFER_CMD, CMD_RESET);
      rchk(A_GEN_STATUS, 16'h0000);
      wr(A_COUNT_MODE, 16'hA5C3);
      chk(mode_q, 16'hA5C3, 16'hFFFF);
      rchk(A_COUNT_MODE, 16'hA5C3);
      wr(11'h7FF, 16'hFFFF);
      rchk(11'h7FF, 16'h0000);
      $display("test registers done");
      @(negedge clk) {evt, ovf[3]} = {GS_ALL, 16'hFFFF};
      @(negedge clk) {evt, ovf[3]} = '0;
      rchk(A_GEN_STATUS, 16'h000F);
      wr(A_GEN_STATUS, 16'hFFFA);
      rchk(A_GEN_STATUS, 16'h000A);
      // clearing write and a fifo overflow in the same cycle: the set wins
      @(negedge clk);
      hq = '{1'b1, 1'b0, A_GEN_STATUS, 16'h0000};
      evt = 4'h2;
      tog ^= 1;
      @(negedge clk);
      hq.wr = 1'b0;
      evt = '0;
      rchk(A_GEN_STATUS, 16'h0002);
      // one clock stands for the line clocks, which run throughout
      rchk(11'h413, OVF_MASK);
      wr(11'h413, 16'h0000);
      rchk(11'h413, 16'h0000);
      $display("test status done");
      lag = 4'h6;
      wr(A_CNT_SEL, 16'h00E5);
      wr(A_BYTE3, 16'h00AB);
      wr(A_BYTES21, 16'hCDEF);
      wr(A_XFER_CMD, 16'h0001);
      rchk(A_XFER_CMD, 16'h0001);
      poll();
      wr(A_BYTE3, 16'h0000);
      wr(A_BYTES21, 16'h0000);
      cmd(16'h0005);
      rchk(A_BYTE3, 16'h00AB);
      rchk(A_BYTES21, 16'hCDEF);
      lag = 4'h0;
      cmd(16'h000A);
      cmd(16'h0006);
      rchk(A_XFER_CMD, 16'h008E);
      cmd(16'h0002);
      cmd(16'h000D);
      cmd(16'h0006);
      rchk(A_XFER_CMD, 16'h0086);
      cmd(16'h0000);
      cmd(16'h0005);
      rchk(A_BYTE3, 16'h0000);
      rchk(A_BYTES21, 16'h0000);
      $display("test transfer done");
      wr(A_XFER_CMD, 16'h0103);
      strobes(3, 16'h0003);
      wr(A_XFER_CMD, 16'h0203);
      strobes(8, 16'h0002);
      wr(A_XFER_CMD, 16'h0003);
      strobes(4, 16'h0000);
      wr(A_XFER_CMD, 16'h0703);
      wr(A_XFER_CMD, 16'h0703);
      wr(A_XFER_CMD, 16'h0303);
      wr(A_XFER_CMD, 16'h0703);
      strobes(0, 16'h0002);
      $display("test latch done");
      end_of_test();
   end
endmodule

// >>> verif/counter_store_model.sv
`timescale 1ns/10ps
// counter side: answers after lag cycles, idle data wanders
module counter_store_model (
   input  wire logic              clk,
   input  wire logic              arst_n,
   input  wire logic [3:0]        lag,
   input  wire cca_pkg::cnt_req_t req,
   output cca_pkg::cnt_rsp_t      rsp
);
   import cca_pkg::*;
   logic [23:0] val_r [512]; // one word per type and link
   logic        ie_r  [512];
   logic [3:0]  wait_r;
   wire  [8:0]  idx = {req.ctype, req.link};
   always @(posedge clk or negedge arst_n)
      if (!arst_n)
      begin
         rsp    <= '0;
         wait_r <= '0;
         for (int i = 0; i < 512; i++)
         begin
            val_r[i] = '0;
            ie_r[i]  = 1'b0;
         end
      end
      else if (req.valid && !rsp.ack && wait_r == lag)
      begin
         rsp    <= '{1'b1, val_r[idx], ie_r[idx]};
         wait_r <= '0;
         case (req.op)
            OP_CLEAR:  for (int i = 0; i < 512; i++) val_r[i] = '0;
            OP_WR_VAL: val_r[idx] = req.wdata;
            OP_WR_IE:  ie_r[idx] = req.ie;
            default:   ;
         endcase
      end
      else
      begin
         // released lines show no stale value
         rsp    <= '{1'b0, ~rsp.rdata, ~rsp.ie};
         wait_r <= req.valid ? wait_r + 4'h1 : 4'h0;
      end
endmodule
